// *** verilog/fmt_threshold.sv ***
// Freefall and motion threshold registers, axis combination and debounce counter.
module fmt_threshold
	import fmt_pkg::*;
(
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic [FMT_ADDR_W-1:0] reg_addr,
	input wire logic [FMT_DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [FMT_DATA_W-1:0] reg_rdata,
	input wire logic sample_valid,
	input wire logic signed [FMT_ACC_W-1:0] accel_x,
	input wire logic signed [FMT_ACC_W-1:0] accel_y,
	input wire logic signed [FMT_ACC_W-1:0] accel_z,
	input wire logic motion_select,
	input wire logic [2:0] axis_enable,
	input wire logic latch_enable,
	input wire logic [FMT_CNT_W-1:0] debounce_count,
	input wire logic hybrid_mode,
	input wire logic src_read,
	output logic event_active_flag,
	output logic [5:0] axis_event_flags,
	output logic [FMT_CNT_W-1:0] debounce_counter,
	output logic transient_share_en
);
	logic [7:0] common_motion_threshold_reg;
	logic [7:0] x_axis_threshold_high_reg;
	logic [7:0] x_axis_threshold_low_reg;
	logic [7:0] y_axis_threshold_high_reg;
	logic [7:0] y_axis_threshold_low_reg;
	logic [7:0] z_axis_threshold_high_reg;
	logic [7:0] z_axis_threshold_low_reg;
	logic [FMT_CNT_W-1:0] cnt_reg;
	logic [FMT_CNT_W-1:0] cnt_next;
	logic half_reg;
	logic ea_reg;
	logic [5:0] flags_reg;
	logic [5:0] flags_next;
	logic step;
	logic cond;
	logic clear_mode;
	logic per_axis_en;
	logic frozen;
	logic [FMT_THR_W-1:0] thr_x;
	logic [FMT_THR_W-1:0] thr_y;
	logic [FMT_THR_W-1:0] thr_z;
	logic [2:0] above;
	logic [2:0] below;
	logic [2:0] negative;
	logic [2:0] hit;

	function automatic logic [FMT_THR_W-1:0] join_thr(input logic [7:0] high, input logic [7:0] low);
		join_thr = {high[FMT_SHR_W-1:0], low[FMT_TOP_BIT:FMT_LOW_LSB]};
	endfunction

	assign clear_mode = common_motion_threshold_reg[FMT_TOP_BIT];
	assign per_axis_en = x_axis_threshold_high_reg[FMT_TOP_BIT];
	assign transient_share_en = y_axis_threshold_high_reg[FMT_TOP_BIT];

	// Register writes.
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			common_motion_threshold_reg <= FMT_REG_RESET;
			x_axis_threshold_high_reg <= FMT_REG_RESET;
			x_axis_threshold_low_reg <= FMT_REG_RESET;
			y_axis_threshold_high_reg <= FMT_REG_RESET;
			y_axis_threshold_low_reg <= FMT_REG_RESET;
			z_axis_threshold_high_reg <= FMT_REG_RESET;
			z_axis_threshold_low_reg <= FMT_REG_RESET;
		end else if (reg_wr) begin
			if (reg_addr == FMT_OFS_COMMON) begin
				common_motion_threshold_reg <= reg_wdata;
			end else if (reg_addr == FMT_OFS_X_HIGH) begin
				x_axis_threshold_high_reg <= reg_wdata;
			end else if (reg_addr == FMT_OFS_X_LOW) begin
				x_axis_threshold_low_reg <= {reg_wdata[FMT_TOP_BIT:FMT_LOW_LSB], 2'h0};
			end else if (reg_addr == FMT_OFS_Y_HIGH) begin
				y_axis_threshold_high_reg <= reg_wdata;
			end else if (reg_addr == FMT_OFS_Y_LOW) begin
				y_axis_threshold_low_reg <= {reg_wdata[FMT_TOP_BIT:FMT_LOW_LSB], 2'h0};
			end else if (reg_addr == FMT_OFS_Z_HIGH) begin
				z_axis_threshold_high_reg <= {1'b0, reg_wdata[FMT_SHR_W-1:0]};
			end else if (reg_addr == FMT_OFS_Z_LOW) begin
				z_axis_threshold_low_reg <= {reg_wdata[FMT_TOP_BIT:FMT_LOW_LSB], 2'h0};
			end
		end
	end

	// Registered read data; unmapped offsets read zero.
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			reg_rdata <= FMT_REG_RESET;
		end else if (reg_rd) begin
			if (reg_addr == FMT_OFS_COMMON) begin
				reg_rdata <= common_motion_threshold_reg;
			end else if (reg_addr == FMT_OFS_X_HIGH) begin
				reg_rdata <= x_axis_threshold_high_reg;
			end else if (reg_addr == FMT_OFS_X_LOW) begin
				reg_rdata <= x_axis_threshold_low_reg;
			end else if (reg_addr == FMT_OFS_Y_HIGH) begin
				reg_rdata <= y_axis_threshold_high_reg;
			end else if (reg_addr == FMT_OFS_Y_LOW) begin
				reg_rdata <= y_axis_threshold_low_reg;
			end else if (reg_addr == FMT_OFS_Z_HIGH) begin
				reg_rdata <= z_axis_threshold_high_reg;
			end else if (reg_addr == FMT_OFS_Z_LOW) begin
				reg_rdata <= z_axis_threshold_low_reg;
			end else begin
				reg_rdata <= FMT_REG_RESET;
			end
		end
	end

	// Threshold selection; combinational from the registers, so a new threshold value applies from the next cycle.
	always_comb begin
		if (per_axis_en) begin
			thr_x = join_thr(x_axis_threshold_high_reg, x_axis_threshold_low_reg);
			thr_y = join_thr(y_axis_threshold_high_reg, y_axis_threshold_low_reg);
			thr_z = join_thr(z_axis_threshold_high_reg, z_axis_threshold_low_reg);
		end else begin
			thr_x = FMT_THR_W'(common_motion_threshold_reg[FMT_SHR_W-1:0]);
			thr_y = thr_x;
			thr_z = thr_x;
		end
	end

	fmt_axis_cmp u_cmp_x (.sample(accel_x), .threshold(thr_x), .above(above[0]), .below(below[0]),
		.negative(negative[0]));
	fmt_axis_cmp u_cmp_y (.sample(accel_y), .threshold(thr_y), .above(above[1]), .below(below[1]),
		.negative(negative[1]));
	fmt_axis_cmp u_cmp_z (.sample(accel_z), .threshold(thr_z), .above(above[2]), .below(below[2]),
		.negative(negative[2]));

	// Axis combination, identical in both threshold modes.
	always_comb begin
		if (motion_select) begin
			hit = above & axis_enable;
			cond = |hit;
		end else begin
			hit = below & axis_enable;
			cond = (axis_enable != 3'h0) && ((below | ~axis_enable) == 3'h7);
		end
		flags_next = {hit[2], hit[2] & negative[2], hit[1], hit[1] & negative[1], hit[0], hit[0] & negative[0]};
	end

	// Hybrid mode uses every second sample.
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			half_reg <= 1'b0;
		end else if (sample_valid) begin
			half_reg <= ~half_reg;
		end
	end
	assign step = sample_valid && (!hybrid_mode || half_reg);

	// Debounce counter; clear mode acts the same for both threshold sources.
	always_comb begin
		if (cond) begin
			cnt_next = (cnt_reg < debounce_count) ? cnt_reg + FMT_CNT_ONE : debounce_count;
		end else if (clear_mode) begin
			cnt_next = FMT_CNT_ZERO;
		end else if (cnt_reg != FMT_CNT_ZERO) begin
			cnt_next = cnt_reg - FMT_CNT_ONE;
		end else begin
			cnt_next = FMT_CNT_ZERO;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			cnt_reg <= FMT_CNT_ZERO;
		end else if (step) begin
			cnt_reg <= cnt_next;
		end
	end
	assign debounce_counter = cnt_reg;

	// Source flags; a new event in the read cycle wins over the clear.
	assign frozen = latch_enable && ea_reg && !src_read;
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			ea_reg <= 1'b0;
			flags_reg <= 6'h00;
		end else if (step && !frozen) begin
			ea_reg <= cond && (cnt_next == debounce_count);
			flags_reg <= flags_next;
		end else if (src_read && latch_enable) begin
			ea_reg <= 1'b0;
			flags_reg <= 6'h00;
		end
	end
	assign event_active_flag = ea_reg;
	assign axis_event_flags = flags_reg;

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (srst);

	a_clear_mode_zero: assert property (step && clear_mode && !cond |=> cnt_reg == FMT_CNT_ZERO)
		else $error("counter not cleared in clear mode");
	a_decrement_one: assert property (step && !clear_mode && !cond && cnt_reg != FMT_CNT_ZERO
		|=> cnt_reg == $past(cnt_reg) - FMT_CNT_ONE) else $error("counter did not decrement by one");
	a_count_saturate: assert property (step && cond && cnt_reg == debounce_count
		|=> cnt_reg == $past(debounce_count)) else $error("counter moved past limit");
	a_event_raise: assert property (step && !frozen && cond && cnt_next == debounce_count
		|=> event_active_flag) else $error("event flag not raised at count");
	a_hybrid_skip: assert property (hybrid_mode && sample_valid && !half_reg |=> $stable(cnt_reg))
		else $error("counter stepped on skipped hybrid sample");
	a_latch_hold: assert property (latch_enable && event_active_flag && !src_read
		|=> event_active_flag && $stable(axis_event_flags)) else $error("latched flags changed");
	a_freefall_all: assert property (!motion_select && cond |-> (below & axis_enable) == axis_enable)
		else $error("freefall with an axis not below");
	a_motion_any: assert property (motion_select && cond |-> (above & axis_enable) != 3'h0)
		else $error("motion with no axis above");
	a_reset_zero: assert property ($past(srst) |-> common_motion_threshold_reg == FMT_REG_RESET
		&& x_axis_threshold_high_reg == FMT_REG_RESET && cnt_reg == FMT_CNT_ZERO && !ea_reg)
		else $error("fields not zero after reset");
	a_shared_ignored: assert property (per_axis_en |-> thr_x == join_thr(x_axis_threshold_high_reg,
		x_axis_threshold_low_reg)) else $error("shared threshold used in per-axis mode");

	c_freefall_event: cover property (step && !motion_select && cond ##1 event_active_flag);
	c_motion_event: cover property (step && motion_select && cond ##1 event_active_flag);
	c_decrement_path: cover property (step && !clear_mode && !cond && cnt_reg != FMT_CNT_ZERO);
	c_latched_clear: cover property (latch_enable && event_active_flag && src_read ##1 !event_active_flag);
endmodule

// *** verilog/fmt_pkg.sv ***
// Package with register map, field layout and sizing constants for the threshold block.
package fmt_pkg;
	localparam int FMT_ADDR_W = 8;
	localparam int FMT_DATA_W = 8;
	localparam int FMT_ACC_W = 14;
	localparam int FMT_THR_W = 13;
	localparam int FMT_SHR_W = 7;
	localparam int FMT_LOW_W = 6;
	localparam int FMT_CNT_W = 8;
	localparam int FMT_MAG_SHIFT = 1;
	localparam logic [7:0] FMT_OFS_COMMON = 8'h17;
	localparam logic [7:0] FMT_OFS_X_HIGH = 8'h73;
	localparam logic [7:0] FMT_OFS_X_LOW = 8'h74;
	localparam logic [7:0] FMT_OFS_Y_HIGH = 8'h75;
	localparam logic [7:0] FMT_OFS_Y_LOW = 8'h76;
	localparam logic [7:0] FMT_OFS_Z_HIGH = 8'h77;
	localparam logic [7:0] FMT_OFS_Z_LOW = 8'h78;
	localparam logic [7:0] FMT_REG_RESET = 8'h00;
	localparam int FMT_TOP_BIT = 7;
	localparam int FMT_LOW_LSB = 2;
	localparam int FMT_SRC_EA = 7;
	localparam logic [7:0] FMT_CNT_ZERO = 8'h00;
	localparam logic [7:0] FMT_CNT_ONE = 8'h01;
endpackage

// *** verilog/fmt_axis_cmp.sv ***
// One axis: magnitude of the signed sample compared with its threshold.
module fmt_axis_cmp
	import fmt_pkg::*;
(
	input wire logic signed [FMT_ACC_W-1:0] sample,
	input wire logic [FMT_THR_W-1:0] threshold,
	output logic above,
	output logic below,
	output logic negative
);
	logic [FMT_ACC_W-1:0] mag_full;
	logic [FMT_THR_W-1:0] mag;

	// Absolute value, then shifted onto the threshold scale.
	always_comb begin
		if (sample[FMT_ACC_W-1]) begin
			mag_full = FMT_ACC_W'(-sample);
			if (mag_full[FMT_ACC_W-1]) begin
				mag_full = {1'b0, {(FMT_ACC_W-1){1'b1}}};
			end
		end else begin
			mag_full = FMT_ACC_W'(sample);
		end
		mag = mag_full[FMT_THR_W-1+FMT_MAG_SHIFT:FMT_MAG_SHIFT];
		above = mag > threshold;
		below = mag < threshold;
		negative = sample[FMT_ACC_W-1];
	end
endmodule

// *** verif/fmt_host_model.sv ***
// Host processor model driving the register strobes of the threshold block.
module fmt_host_model
	import fmt_pkg::*;
(
	input wire logic clk_sys,
	output logic [FMT_ADDR_W-1:0] reg_addr,
	output logic [FMT_DATA_W-1:0] reg_wdata,
	output logic reg_wr,
	output logic reg_rd,
	input wire logic [FMT_DATA_W-1:0] reg_rdata
);
	timeunit 1ns;
	timeprecision 1ns;
	logic axis_en_reg = 1'b0;
	logic share_en_reg = 1'b0;
	initial begin
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		#1;
		if ((a == FMT_OFS_X_HIGH && share_en_reg) || (a == FMT_OFS_Y_HIGH && axis_en_reg)) begin
			d[7] = 1'b0;
		end
		if (a == FMT_OFS_X_HIGH) begin
			axis_en_reg = d[7];
		end
		if (a == FMT_OFS_Y_HIGH) begin
			share_en_reg = d[7];
		end
		{reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
		@(posedge clk_sys);
		#1;
		{reg_addr, reg_wdata, reg_wr} = {~a, ~d, 1'b0};
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_sys);
		#1;
		{reg_addr, reg_rd} = {a, 1'b1};
		@(posedge clk_sys);
		#1;
		d = reg_rdata;
		{reg_addr, reg_rd} = {~a, 1'b0};
	endtask
endmodule

// *** verif/tb_top.sv ***
// Self-checking testbench for the freefall and motion threshold block.
module tb_top
	import fmt_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys, srst, reg_wr, reg_rd, sample_valid, motion_select, latch_enable, hybrid_mode, src_read;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, debounce_count, debounce_counter;
	logic signed [13:0] accel_x, accel_y, accel_z;
	logic [2:0] axis_enable;
	logic [5:0] axis_event_flags;
	logic event_active_flag, transient_share_en;
	int miscompares = 0;
	int check_count = 0;
	fmt_threshold u_fmt_threshold (.clk_sys(clk_sys), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sample_valid(sample_valid), .accel_x(accel_x),
		.accel_y(accel_y), .accel_z(accel_z), .motion_select(motion_select), .axis_enable(axis_enable),
		.latch_enable(latch_enable), .debounce_count(debounce_count), .hybrid_mode(hybrid_mode),
		.src_read(src_read), .event_active_flag(event_active_flag), .axis_event_flags(axis_event_flags),
		.debounce_counter(debounce_counter), .transient_share_en(transient_share_en));
	fmt_host_model u_fmt_host_model (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		check_count++;
		if (g !== e) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic rdc(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		u_fmt_host_model.rd(a, d);
		chk("rdata", e, d);
	endtask
	task automatic smp(input logic signed [13:0] x, input logic signed [13:0] y, input logic signed [13:0] z);
		@(posedge clk_sys);
		#1;
		{accel_x, accel_y, accel_z, sample_valid} = {x, y, z, 1'b1};
		@(posedge clk_sys);
		#1;
		sample_valid = 1'b0;
	endtask
	task automatic chk_ev(input logic [7:0] c, input logic ea, input logic [5:0] fl);
		chk("counter", c, debounce_counter);
		chk("event", {7'h00, ea}, {7'h00, event_active_flag});
		chk("flags", {2'b00, fl}, {2'b00, axis_event_flags});
	endtask
	task automatic t_reset();
		logic [7:0] ofs [7] = '{8'h17, 8'h73, 8'h74, 8'h75, 8'h76, 8'h77, 8'h78};
		foreach (ofs[i]) rdc(ofs[i], 8'h00);
		rdc(8'h20, 8'h00);
		chk_ev(8'h00, 1'b0, 6'h00);
	endtask
	task automatic t_regs();
		u_fmt_host_model.wr(8'h17, 8'h85);
		rdc(8'h17, 8'h85);
		u_fmt_host_model.wr(8'h74, 8'hFF);
		rdc(8'h74, 8'hFC);
		u_fmt_host_model.wr(8'h77, 8'hFF);
		rdc(8'h77, 8'h7F);
		u_fmt_host_model.wr(8'h75, 8'h80);
		chk("share", 8'h01, {7'h00, transient_share_en});
		u_fmt_host_model.wr(8'h75, 8'h00);
		u_fmt_host_model.wr(8'h74, 8'h00);
		u_fmt_host_model.wr(8'h77, 8'h00);
	endtask
	task automatic t_freefall();
		u_fmt_host_model.wr(8'h17, 8'h0A);
		{motion_select, axis_enable, debounce_count} = {1'b0, 3'b001, 8'h02};
		smp(14'h13, 14'h1F40, 14'h1F40);
		chk_ev(8'h01, 1'b0, 6'h02);
		smp(-14'sh13, 14'h00, 14'h00);
		chk_ev(8'h02, 1'b1, 6'h03);
		smp(14'h13, 14'h00, 14'h00);
		chk_ev(8'h02, 1'b1, 6'h02);
		smp(14'h14, 14'h00, 14'h00);
		chk_ev(8'h01, 1'b0, 6'h00);
		axis_enable = 3'b111;
		smp(14'h13, 14'h13, 14'h28);
		chk_ev(8'h00, 1'b0, 6'h0A);
		smp(14'h13, 14'h13, 14'h13);
		smp(14'h13, 14'h13, 14'h13);
		chk("counter", 8'h02, debounce_counter);
		u_fmt_host_model.wr(8'h17, 8'h8A);
		smp(14'h14, 14'h00, 14'h00);
		chk("counter", 8'h00, debounce_counter);
	endtask
	task automatic t_motion();
		u_fmt_host_model.wr(8'h17, 8'h01);
		u_fmt_host_model.wr(8'h73, 8'h81);
		u_fmt_host_model.wr(8'h74, 8'h08);
		{motion_select, axis_enable, debounce_count} = {1'b1, 3'b001, 8'h03};
		smp(14'h85, 14'h00, 14'h00);
		chk_ev(8'h00, 1'b0, 6'h00);
		smp(-14'sh86, 14'h00, 14'h00);
		chk_ev(8'h01, 1'b0, 6'h03);
		smp(14'h86, 14'h00, 14'h00);
		chk("counter", 8'h02, debounce_counter);
		smp(14'h00, 14'h00, 14'h00);
		chk("counter", 8'h01, debounce_counter);
		u_fmt_host_model.wr(8'h17, 8'h81);
		smp(14'h86, 14'h00, 14'h00);
		smp(14'h00, 14'h00, 14'h00);
		chk("counter", 8'h00, debounce_counter);
		u_fmt_host_model.wr(8'h73, 8'h00);
	endtask
	task automatic t_midreset();
		@(posedge clk_sys);
		#1;
		srst = 1'b1;
		{sample_valid, latch_enable, hybrid_mode, src_read} = 4'h0;
		repeat (2) @(posedge clk_sys);
		#1;
		srst = 1'b0;
		t_reset();
	endtask
	task automatic t_hybrid();
		u_fmt_host_model.wr(8'h17, 8'h0A);
		{motion_select, axis_enable, debounce_count, hybrid_mode} = {1'b0, 3'b001, 8'h03, 1'b1};
		smp(14'h00, 14'h00, 14'h00);
		chk("counter", 8'h00, debounce_counter);
		smp(14'h00, 14'h00, 14'h00);
		chk("counter", 8'h01, debounce_counter);
		smp(14'h00, 14'h00, 14'h00);
		chk("counter", 8'h01, debounce_counter);
		smp(14'h00, 14'h00, 14'h00);
		chk("counter", 8'h02, debounce_counter);
		hybrid_mode = 1'b0;
	endtask
	task automatic t_latch();
		latch_enable = 1'b1;
		smp(-14'sh13, 14'h00, 14'h00);
		chk_ev(8'h03, 1'b1, 6'h03);
		smp(14'h14, 14'h00, 14'h00);
		chk_ev(8'h02, 1'b1, 6'h03);
		@(posedge clk_sys);
		#1;
		src_read = 1'b1;
		@(posedge clk_sys);
		#1;
		src_read = 1'b0;
		chk_ev(8'h02, 1'b0, 6'h00);
		smp(14'h13, 14'h00, 14'h00);
		chk_ev(8'h03, 1'b1, 6'h02);
		@(posedge clk_sys);
		#1;
		{accel_x, sample_valid, src_read} = {-14'sh13, 1'b1, 1'b1};
		@(posedge clk_sys);
		#1;
		{sample_valid, src_read} = 2'b00;
		chk_ev(8'h03, 1'b1, 6'h03);
		latch_enable = 1'b0;
	endtask
	task automatic print_verdict();
		$display("checks %0d miscompares %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	initial begin
		{srst, sample_valid, motion_select, latch_enable, hybrid_mode, src_read} = 6'b100000;
		{accel_x, accel_y, accel_z, axis_enable, debounce_count} = '0;
		repeat (12) @(posedge clk_sys);
		#1;
		srst = 1'b0;
		t_reset();
		t_regs();
		t_freefall();
		t_motion();
		t_midreset();
		t_hybrid();
		t_latch();
		print_verdict();
	end
endmodule
